// ---- core/sdp_sram_ctl.sv ----
// ddr sram port, controller end with register port
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdp_sram_ctl
  import sdp_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [3:0]  addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [DW-1:0]    rdata,
  sdp_link_if.ctl          lnk
);

  typedef enum logic [1:0] {S_RST, S_CAL, S_IDLE, S_OP} sdp_ctl_state_t;

  typedef struct packed {
    sdp_ctl_state_t st;
    logic          mck;
    logic [5:0]    ctrl;
    logic [5:0]    lctrl;
    logic [AW-1:0] addr;
    logic [DW-1:0] wd0;
    logic [DW-1:0] wd1;
    logic [DW-1:0] rd0;
    logic [DW-1:0] rd1;
    logic          busy;
    logic          is_rd;
    logic          rddone;
    logic          ready;
    logic [17:0]   cal;
    logic [2:0]    t;
    logic          ld_n;
    logic          rw;
    logic [AW-1:0] aout;
    logic [DW-1:0] dqo;
    logic          dqdrv;
    logic [1:0]    kd;
    logic [DW-1:0] rdata;
  } sdp_ctl_st_t;

  sdp_ctl_st_t s_r;
  sdp_ctl_st_t s_nxt;
  logic        tick;

  // link outputs change on the falling link edge
  assign tick = s_r.mck;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.mck = ~s_r.mck;
    if (rd) begin
      unique case (addr)
        REG_ADDR: s_nxt.rdata = DW'(s_r.addr);
        REG_WD0:  s_nxt.rdata = s_r.wd0;
        REG_WD1:  s_nxt.rdata = s_r.wd1;
        REG_STAT: s_nxt.rdata = DW'({s_r.rddone, s_r.ready, s_r.busy});
        REG_RD0:  s_nxt.rdata = s_r.rd0;
        REG_RD1:  s_nxt.rdata = s_r.rd1;
        REG_CTRL: s_nxt.rdata = DW'(s_r.ctrl);
        default:  s_nxt.rdata = '0;
      endcase
    end
    if (wr) begin
      unique case (addr)
        REG_ADDR: s_nxt.addr = wdata[AW-1:0];
        REG_WD0:  s_nxt.wd0  = wdata;
        REG_WD1:  s_nxt.wd1  = wdata;
        REG_CTRL: s_nxt.ctrl = wdata[5:0];
        REG_CMD: begin
          if (wdata[CMD_GO_BIT] && !s_r.busy) begin
            s_nxt.busy   = 1'b1;
            s_nxt.is_rd  = wdata[CMD_RD_BIT];
            s_nxt.rddone = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (tick) begin
      // straps and device reset move only away from the link's rising edge
      s_nxt.lctrl = s_r.ctrl;
      unique case (s_r.st)
        S_RST: begin
          s_nxt.cal = '0;
          if (!s_r.ctrl[CTRL_RST_BIT]) begin
            s_nxt.st = S_CAL;
          end
        end
        // nop cycles until calibration time elapses
        S_CAL: begin
          s_nxt.cal = s_r.cal + 18'h1;
          if (s_r.cal >= 18'(CAL_CYCLES - 1)) begin
            s_nxt.st    = S_IDLE;
            s_nxt.ready = 1'b1;
          end
        end
        S_IDLE: begin
          if (s_r.busy) begin
            // address and controls set up for the next rise
            s_nxt.ld_n = 1'b0;
            s_nxt.rw   = s_r.is_rd;
            s_nxt.aout = s_r.addr;
            s_nxt.t    = 3'h1;
            s_nxt.st   = S_OP;
          end
        end
        S_OP: begin
          s_nxt.t    = s_r.t + 3'h1;
          s_nxt.ld_n = 1'b1;
          if (!s_r.is_rd) begin
            // data with write clocks, one link cycle after the request
            // both data clock pairs strobe their groups
            unique case (s_r.t)
              T_WR_BEAT0: begin
                s_nxt.dqo   = s_r.wd0;
                s_nxt.dqdrv = 1'b1;
                s_nxt.kd    = 2'h3;
              end
              T_WR_BEAT1: s_nxt.dqo = s_r.wd1;
              T_WR_END: begin
                s_nxt.dqdrv = 1'b0;
                s_nxt.kd    = 2'h0;
                s_nxt.busy  = 1'b0;
                s_nxt.st    = S_IDLE;
              end
              default: ;
            endcase
          end else begin
            // read beats sampled at fixed latency
            if (s_r.t == T_RD_BEAT0) begin
              s_nxt.rd0 = lnk.dq;
            end
            if (s_r.t == T_RD_BEAT1) begin
              s_nxt.rd1    = lnk.dq;
              s_nxt.rddone = 1'b1;
              s_nxt.busy   = 1'b0;
              s_nxt.st     = S_IDLE;
            end
          end
        end
      endcase
      if (s_r.ctrl[CTRL_RST_BIT]) begin
        s_nxt.st    = S_RST;
        s_nxt.ready = 1'b0;
        s_nxt.ld_n  = 1'b1;
        s_nxt.dqdrv = 1'b0;
        s_nxt.kd    = 2'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_r      <= '0;
      s_r.st   <= S_RST;
      s_r.ctrl <= CTRL_RESET_VAL;
      s_r.lctrl <= CTRL_RESET_VAL;
      s_r.ld_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata                     = s_r.rdata;
  assign lnk.mck                   = s_r.mck;
  assign lnk.mck_n                 = ~s_r.mck;
  assign lnk.load_strobe_n         = s_r.ld_n;
  assign lnk.rd_not_wr             = s_r.rw;
  assign lnk.word_address_in       = s_r.aout;
  assign lnk.wdclk                 = s_r.kd;
  assign lnk.wdclk_n               = ~s_r.kd;
  assign lnk.dq_ctl_o              = s_r.dqo;
  assign lnk.dq_ctl_oe_n           = ~s_r.dqdrv;
  // straps come from static control bits
  assign lnk.dev_reset             = s_r.lctrl[CTRL_RST_BIT];
  assign lnk.org_wide              = s_r.lctrl[CTRL_WIDE_BIT];
  assign lnk.termination_mode_sel  = s_r.lctrl[CTRL_MODE_LSB +: 2];
  assign lnk.termination_group_sel = s_r.lctrl[CTRL_GRP_LSB +: 2];

endmodule : sdp_sram_ctl
`default_nettype wire

// ---- core/sdp_pkg.sv ----
// shared constants and helpers for the ddr sram port link
package sdp_pkg;

  localparam int AW    = 8;
  localparam int DW    = 36;
  localparam int DEPTH = 256;

  // controller register offsets
  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WD0  = 4'h2;
  localparam logic [3:0] REG_WD1  = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RD0  = 4'h5;
  localparam logic [3:0] REG_RD1  = 4'h6;
  localparam logic [3:0] REG_CTRL = 4'h7;

  // field positions
  localparam int CMD_GO_BIT    = 0;
  localparam int CMD_RD_BIT    = 1;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_READY_BIT  = 1;
  localparam int ST_RDDONE_BIT = 2;
  localparam int CTRL_RST_BIT  = 0;
  localparam int CTRL_WIDE_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_GRP_LSB  = 4;

  // reset values
  localparam logic [5:0] CTRL_RESET_VAL = 6'h01;

  // cycle counts, in link clock cycles
  localparam int RD_LATENCY     = 3;
  localparam int CAL_CYCLES_DEF = 163840;
  localparam logic [2:0] T_WR_BEAT0 = 3'h1;
  localparam logic [2:0] T_WR_BEAT1 = 3'h2;
  localparam logic [2:0] T_WR_END   = 3'h3;
  localparam logic [2:0] T_RD_BEAT0 = 3'(RD_LATENCY + 1);
  localparam logic [2:0] T_RD_BEAT1 = 3'(RD_LATENCY + 2);

  // termination mode codes
  localparam logic [1:0] ODT_OFF    = 2'h0;
  localparam logic [1:0] ODT_STRONG = 2'h1;
  localparam logic [1:0] ODT_WEAK   = 2'h2;

  // data lines owned by a group in a given organisation
  function automatic logic [DW-1:0] sdp_lane_mask(input logic grp, input logic wide);
    if (wide) begin
      sdp_lane_mask = grp ? 36'hF_FFFC_0000 : 36'h0_0003_FFFF;
    end else begin
      sdp_lane_mask = grp ? 36'h0_0003_FE00 : 36'h0_0000_01FF;
    end
  endfunction : sdp_lane_mask

endpackage : sdp_pkg

// ---- core/sdp_link_if.sv ----
// pin-level link between memory controller and ddr sram port
`timescale 1ns/1ps
`default_nettype none
interface sdp_link_if;
  import sdp_pkg::*;
  logic          mck;
  logic          mck_n;
  logic          load_strobe_n;
  logic          rd_not_wr;
  logic [AW-1:0] word_address_in;
  logic [1:0]    wdclk;
  logic [1:0]    wdclk_n;
  logic [1:0]    echo_clk;
  logic [1:0]    echo_clk_n;
  logic [1:0]    read_valid_flag;
  logic          dev_reset;
  logic [1:0]    termination_mode_sel;
  logic [1:0]    termination_group_sel;
  logic          org_wide;
  logic [DW-1:0] dq_dev_o;
  logic          dq_dev_oe_n;
  logic [DW-1:0] dq_ctl_o;
  logic          dq_ctl_oe_n;
  wire  [DW-1:0] dq;

  // shared data bus resolved from the two enables, pulled low when released
  assign dq = !dq_dev_oe_n ? dq_dev_o : (!dq_ctl_oe_n ? dq_ctl_o : '0);

  modport dev (
    input  mck, mck_n, load_strobe_n, rd_not_wr, word_address_in, wdclk, wdclk_n,
           dev_reset, termination_mode_sel, termination_group_sel, org_wide, dq,
    output echo_clk, echo_clk_n, read_valid_flag, dq_dev_o, dq_dev_oe_n
  );
  modport ctl (
    output mck, mck_n, load_strobe_n, rd_not_wr, word_address_in, wdclk, wdclk_n,
           dev_reset, termination_mode_sel, termination_group_sel, org_wide,
           dq_ctl_o, dq_ctl_oe_n,
    input  echo_clk, echo_clk_n, read_valid_flag, dq
  );
endinterface : sdp_link_if
`default_nettype wire

// ---- core/sdp_sram_dev.sv ----
// ddr sram port, device end, clocked by the master clock of the link
// Operation
// - address captured on rising master clock
// - write via data clocks, read with echo
// - narrow uses lines 17:0, wide 35:0
// - read valid raised ahead of data
// - data clock pairs own their line groups
// - echo pairs aligned with their line groups
// - echo clocks run continuously
// - master clock times inputs and outputs
// - load strobe low starts, high is nop
// - select high reads, low writes
// - reset high returns to initial state
// - termination mode decode, 11 reserved
// - termination group decode
// - straps held static by board
// - requests ignored during reset
// - controller waits calibration before operations
`timescale 1ns/1ps
`default_nettype none
module sdp_sram_dev
  import sdp_pkg::*;
(
  sdp_link_if.dev     lnk,
  output logic        odt_strong,
  output logic        odt_weak,
  output logic        odt_wdata,
  output logic        odt_in_clk,
  output logic        odt_addr_ctl
);

  typedef struct packed {
    logic [AW-1:0] a0;
    logic          rd0;
    logic          wr0;
    logic [AW-1:0] a1;
    logic          rd1;
    logic          wr1;
    logic [AW-1:0] a2;
    logic          rd2;
    logic          wr2;
    logic [AW-1:0] a3;
    logic          rd3;
    logic [DW-1:0] wlo;
    logic [DW-1:0] dq;
    logic          drv;
    logic [1:0]    rv;
    logic          cq;
    logic [1:0]    msel;
    logic [1:0]    gsel;
    logic          wide;
  } sdp_dev_st_t;

  sdp_dev_st_t           s_r;
  sdp_dev_st_t           s_nxt;
  logic [2*DW-1:0]       mem [0:DEPTH-1];
  logic                  mem_we;
  logic [DW-1:0]         beat_in;
  logic [DW-1:0]         used;

  // lines the organisation actually carries
  assign used = sdp_lane_mask(1'b0, s_r.wide) | sdp_lane_mask(1'b1, s_r.wide);

  // each data clock pair latches its own group
  always_comb begin
    beat_in = '0;
    for (int g = 0; g < 2; g++) begin
      if (lnk.wdclk[g]) begin
        beat_in = beat_in | (lnk.dq & sdp_lane_mask(g[0], s_r.wide));
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    // load strobe low starts an operation
    s_nxt.a0  = lnk.word_address_in;
    s_nxt.rd0 = !lnk.load_strobe_n && lnk.rd_not_wr;
    s_nxt.wr0 = !lnk.load_strobe_n && !lnk.rd_not_wr;
    s_nxt.a1  = s_r.a0;
    s_nxt.rd1 = s_r.rd0;
    s_nxt.wr1 = s_r.wr0;
    s_nxt.a2  = s_r.a1;
    s_nxt.rd2 = s_r.rd1;
    s_nxt.wr2 = s_r.wr1;
    s_nxt.a3  = s_r.a2;
    s_nxt.rd3 = s_r.rd2;
    // first write beat held for the burst
    if (s_r.wr0) begin
      s_nxt.wlo = beat_in;
    end
    // valid leads the read beats by a cycle
    s_nxt.rv = {2{s_r.rd1 | s_r.rd2}};
    // beats three and four cycles after request
    s_nxt.drv = s_r.rd2 | s_r.rd3;
    if (s_r.rd2) begin
      s_nxt.dq = mem[s_r.a2][DW-1:0] & used;
    end else if (s_r.rd3) begin
      s_nxt.dq = mem[s_r.a3][2*DW-1:DW] & used;
    end
    if (lnk.dev_reset) begin
      s_nxt       = '0;
      // straps are sampled while reset is high
      s_nxt.msel  = lnk.termination_mode_sel;
      s_nxt.gsel  = lnk.termination_group_sel;
      s_nxt.wide  = lnk.org_wide;
    end
    // echo clock toggles every cycle, reset or not
    // unknown start settles to a known phase
    if (s_r.cq) begin
      s_nxt.cq = 1'b0;
    end else begin
      s_nxt.cq = 1'b1;
    end
  end

  // second beat completes the burst write
  assign mem_we = s_r.wr1 && !lnk.dev_reset;

  // every register runs on the master clock
  always_ff @(posedge lnk.mck) begin
    s_r <= s_nxt;
  end

  always_ff @(posedge lnk.mck) begin
    if (mem_we) begin
      mem[s_r.a1] <= {beat_in, s_r.wlo};
    end
  end

  // both echo pairs share the data timing
  assign lnk.echo_clk        = {2{s_r.cq}};
  assign lnk.echo_clk_n      = {2{~s_r.cq}};
  assign lnk.read_valid_flag = s_r.rv;
  assign lnk.dq_dev_o        = s_r.dq;
  assign lnk.dq_dev_oe_n     = ~s_r.drv;

  // mode decode, reserved code gives no termination
  assign odt_strong = (s_r.msel == ODT_STRONG);
  assign odt_weak   = (s_r.msel == ODT_WEAK);
  // group decode when termination is on
  assign odt_wdata    = odt_strong | odt_weak;
  assign odt_in_clk   = (odt_strong | odt_weak) & s_r.gsel[0];
  assign odt_addr_ctl = (odt_strong | odt_weak) & s_r.gsel[1];

endmodule : sdp_sram_dev
`default_nettype wire

// ---- tb/sdp_link_assertions.sv ----
// concurrent checks on the ddr sram port link
`timescale 1ns/1ps
`default_nettype none
module sdp_link_assertions (
  input wire logic       mck,
  input wire logic       dev_reset,
  input wire logic       load_strobe_n,
  input wire logic       rd_not_wr,
  input wire logic [1:0] wdclk,
  input wire logic [1:0] echo_clk,
  input wire logic [1:0] echo_clk_n,
  input wire logic [1:0] read_valid_flag,
  input wire logic       dq_dev_oe_n,
  input wire logic       dq_ctl_oe_n
);
  default clocking cb @(posedge mck); endclocking
  default disable iff (dev_reset);
  wire rd_req = !load_strobe_n && rd_not_wr;
  wire wr_req = !load_strobe_n && !rd_not_wr;

  a_echo_free: assert property (echo_clk == ~$past(echo_clk))
    else $error("echo clock stalled");
  a_echo_pair: assert property (echo_clk_n == ~echo_clk && echo_clk[0] == echo_clk[1])
    else $error("echo clock pairs disagree");
  a_rd_valid: assert property (rd_req |-> ##3 read_valid_flag == 2'h3 [*2] ##1 read_valid_flag == 2'h0)
    else $error("read valid window wrong");
  a_rd_burst: assert property (rd_req |-> ##3 dq_dev_oe_n ##1 !dq_dev_oe_n [*2] ##1 dq_dev_oe_n)
    else $error("read burst not two beats at latency");
  a_valid_lead: assert property ($rose(read_valid_flag[0]) |=> $fell(dq_dev_oe_n))
    else $error("read valid does not lead data");
  a_wr_beats: assert property (wr_req |-> ##1 (wdclk == 2'h3 && !dq_ctl_oe_n) [*2] ##1 wdclk == 2'h0)
    else $error("write beats not strobed");
  a_ld_pulse: assert property ($fell(load_strobe_n) |=> load_strobe_n)
    else $error("load strobe longer than one cycle");
  a_bus_turn: assert property (!dq_dev_oe_n |-> dq_ctl_oe_n)
    else $error("both ends drive data");
  a_wr_quiet: assert property (wdclk != 2'h0 |-> dq_dev_oe_n && read_valid_flag == 2'h0)
    else $error("device active during write beats");
  a_reset_idle: assert property (disable iff (1'h0) dev_reset |=> dq_dev_oe_n && read_valid_flag == 2'h0)
    else $error("device active in reset");

  c_read: cover property (rd_req);
  c_write: cover property (wr_req);
  c_release: cover property (disable iff (1'h0) $fell(dev_reset));
endmodule : sdp_link_assertions
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the ddr sram port link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sdp_pkg::*;
  typedef struct packed {
    logic          wide;
    logic [AW-1:0] adr;
    logic [DW-1:0] d0;
    logic [DW-1:0] d1;
    logic [DW-1:0] e0;
    logic [DW-1:0] e1;
  } sdp_row_t;
  logic          clock;
  logic          rstn;
  logic [3:0]    addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [DW-1:0] rdata;
  logic [4:0]    odt;
  logic [DW-1:0] s;
  logic          en;
  int            n_errors;
  int            checks_done;
  sdp_row_t      rows [4];

  sdp_link_if lnk ();
  sdp_sram_ctl #(.CAL_CYCLES(8)) sdp_sram_ctl_inst (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk));
  sdp_sram_dev sdp_sram_dev_inst (.lnk(lnk), .odt_strong(odt[4]), .odt_weak(odt[3]), .odt_wdata(odt[2]),
    .odt_in_clk(odt[1]), .odt_addr_ctl(odt[0]));
  sdp_link_assertions sdp_link_assertions_inst (.mck(lnk.mck), .dev_reset(lnk.dev_reset),
    .load_strobe_n(lnk.load_strobe_n), .rd_not_wr(lnk.rd_not_wr), .wdclk(lnk.wdclk), .echo_clk(lnk.echo_clk),
    .echo_clk_n(lnk.echo_clk_n), .read_valid_flag(lnk.read_valid_flag), .dq_dev_oe_n(lnk.dq_dev_oe_n),
    .dq_ctl_oe_n(lnk.dq_ctl_oe_n));

  initial clock = 1'h0;
  always #12.5 clock = ~clock;

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [3:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [DW-1:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      rd_reg(REG_STAT, s);
      if (s[b] === v) break;
    end
    if (i == 300) begin
      chk(DW'(s[b]), DW'(v));
      close_out();
    end
  endtask : wait_bit

  task automatic xfer(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1, input logic r);
    wr_reg(REG_ADDR, DW'(a));
    wr_reg(REG_WD0, d0);
    wr_reg(REG_WD1, d1);
    wr_reg(REG_CMD, DW'({r, 1'h1}));
    wait_bit(ST_BUSY_BIT, 1'h0);
  endtask : xfer

  // device reset, strap, release, calibration wait
  task automatic cfg(input logic w);
    wr_reg(REG_CTRL, DW'({w, 1'h1}));
    repeat (4) @(posedge clock);
    wr_reg(REG_CTRL, DW'({w, 1'h0}));
    wait_bit(ST_READY_BIT, 1'h1);
  endtask : cfg

  initial begin
    rstn = 1'h0;
    addr = 4'h0;
    wdata = '0;
    wr = 1'h0;
    rd = 1'h0;
    n_errors = 0;
    checks_done = 0;
    rows[0] = '{1'h1, 8'h00, 36'h0_0000_0001, 36'h8_0000_0000, 36'h0_0000_0001, 36'h8_0000_0000};
    rows[1] = '{1'h1, 8'hFF, 36'hF_FFFF_FFFF, 36'hA_5A5A_5A5A, 36'hF_FFFF_FFFF, 36'hA_5A5A_5A5A};
    rows[2] = '{1'h0, 8'h10, 36'hF_FFFF_FFFF, 36'h5_5555_5555, 36'h0_0003_FFFF, 36'h0_0001_5555};
    rows[3] = '{1'h0, 8'h11, 36'h0_0002_0100, 36'h0_0000_0200, 36'h0_0002_0100, 36'h0_0000_0200};
    repeat (6) @(posedge clock);
    rstn <= 1'h1;
    rd_reg(REG_CTRL, s);
    chk(s, DW'(CTRL_RESET_VAL));
    rd_reg(4'hF, s);
    chk(s, '0);
    $display("test reset values done");
    for (int m = 0; m < 16; m++) begin
      wr_reg(REG_CTRL, DW'({m[3:0], 2'h1}));
      repeat (4) @(posedge clock);
      #1 en = m[1:0] == 2'h1 || m[1:0] == 2'h2;
      // strap decode all codes
      chk(DW'(odt), DW'({m[1:0] == 2'h1, m[1:0] == 2'h2, en, en & m[2], en & m[3]}));
    end
    $display("test strap decode done");
    foreach (rows[i]) begin
      if (i == 0 || rows[i].wide != rows[i-1].wide)
        cfg(rows[i].wide);
      xfer(rows[i].adr, rows[i].d0, rows[i].d1, 1'h0);
      xfer(rows[i].adr, '0, '0, 1'h1);
      rd_reg(REG_RD0, s);
      chk(s, rows[i].e0);
      rd_reg(REG_RD1, s);
      chk(s, rows[i].e1);
    end
    $display("test burst rows done");
    wr_reg(REG_CMD, DW'(2'h1));
    wr_reg(REG_CMD, DW'(2'h3));
    wait_bit(ST_BUSY_BIT, 1'h0);
    // second go refused while busy
    chk(DW'(s[ST_RDDONE_BIT]), '0);
    $display("test busy refusal done");
    wr_reg(REG_CMD, DW'(2'h1));
    rstn <= 1'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    rd_reg(REG_CTRL, s);
    chk(s, DW'(CTRL_RESET_VAL));
    rd_reg(REG_STAT, s);
    chk(DW'(s[ST_READY_BIT]), '0);
    chk(DW'(s[ST_BUSY_BIT]), '0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
